// *** common/paoa_pkg.sv ***
package paoa_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets
   localparam logic [7:0] OFF_CFG = 8'h00;
   localparam logic [7:0] OFF_AL1_CFG = 8'h04;
   localparam logic [7:0] OFF_AL2_CFG = 8'h08;
   localparam logic [7:0] OFF_AL1_LO = 8'h0C;
   localparam logic [7:0] OFF_AL1_HI = 8'h10;
   localparam logic [7:0] OFF_AL2_LO = 8'h14;
   localparam logic [7:0] OFF_AL2_HI = 8'h18;
   localparam logic [7:0] OFF_SP1 = 8'h1C;
   localparam logic [7:0] OFF_SP2 = 8'h20;
   localparam logic [7:0] OFF_STAT = 8'h24;
   localparam logic [7:0] OFF_PV = 8'h28;

   ////////////////////////////////////////////////////////////////////////////
   // input ranges and their scale factors (full range gives 10000 counts)
   localparam logic [1:0] RNG_100MV = 2'h0;
   localparam logic [1:0] RNG_1V = 2'h1;
   localparam logic [1:0] RNG_10V = 2'h2;
   localparam logic [1:0] RNG_20MA = 2'h3;
   localparam logic [31:0] FAC_100MV = 32'h00000064;
   localparam logic [31:0] FAC_1V = 32'h0000000A;
   localparam logic [31:0] FAC_10V = 32'h00000001;
   localparam logic [31:0] FAC_20MA = 32'h000001F4;

   // alarm compare modes
   localparam logic [1:0] MODE_ABOVE = 2'h0;
   localparam logic [1:0] MODE_BELOW = 2'h1;
   localparam logic [1:0] MODE_HILO = 2'h2;
   localparam logic [1:0] MODE_BAND = 2'h3;

   // bus answers
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // field layouts, low bit last
   typedef logic signed [31:0] paoa_val_t;
   typedef struct packed {
      logic run;
      logic an_cur;
      logic an_en;
      logic [1:0] rng;
   } paoa_cfg_t;
   typedef struct packed {
      logic pwr_on;
      logic [1:0] mode;
      logic nc;
      logic latch;
      logic dev;
      logic en;
   } paoa_alcfg_t;

   // whole block state
   typedef struct packed {
      logic [15:0] raw_m;
      logic [15:0] raw_s;
      logic opt_m;
      logic opt_s;
      paoa_val_t pv;
      paoa_cfg_t cfg;
      paoa_alcfg_t [1:0] al;
      paoa_val_t [1:0] lo;
      paoa_val_t [1:0] hi;
      paoa_val_t [1:0] sp;
      logic [1:0] act;
      logic [1:0] armed;
      logic relay1;
      logic relay2;
      logic analog_en;
      logic aw_ok;
      logic [7:0] awaddr;
      logic w_ok;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } paoa_st_t;

   // values after reset: running, 20 mA range, alarms off
   localparam paoa_cfg_t CFG_RST = 5'h13;
   localparam paoa_st_t ST_RST = '{cfg: CFG_RST, default: '0};

endpackage

// *** dv/paoa_field.sv ***
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
// field side: sensor reading in and relay coils out
module paoa_field (
   // clock
   input wire logic clk_i,
   // relay coils
   input wire logic relay1_i,
   input wire logic relay2_i,
   // sensor reading
   output logic [15:0] raw_o
);
   // sensor level, nonzero from the start so the input never floats
   logic [15:0] level_r = 16'h0003;
   logic [1:0] coil_r = 2'h0;
   assign raw_o = level_r;
   // called just after an edge, so the step lands off the sampling edge
   task automatic set_level(input logic [15:0] v);
      level_r <= v;
   endtask
   // coil state as the field equipment sees it
   always @(posedge clk_i) begin
      coil_r <= {relay2_i, relay1_i};
   end
endmodule

// *** dv/tb_process_alarm_and_output_assign.sv ***
`timescale 1ns/1ps
module tb_process_alarm_and_output_assign;
   ////////////////////////////////////////////////////////////////////////////
   // stimulus and observed signals
   logic clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic analog_opt_i = 1'b0;
   logic ctl_out1_i = 1'b1;
   logic ctl_out2_i = 1'b0;
   logic [7:0] awaddr = 8'h00;
   logic [7:0] araddr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [15:0] raw, an_val;
   logic relay1_o, relay2_o, an_en, an_cur;
   int n_fail = 0;
   int tests_run = 0;

   // 40 MHz
   always #12.5 clk_i = ~clk_i;

   paoa_top i_dut (
      .clk_i(clk_i), .rst_i(rst_i), .raw_i(raw),
      .analog_opt_i(analog_opt_i), .ctl_out1_i(ctl_out1_i),
      .ctl_out2_i(ctl_out2_i), .s_axi_awaddr_i(awaddr),
      .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
      .s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
      .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
      .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
      .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
      .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
      .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
      .s_axi_rready_i(rready), .relay1_o(relay1_o), .relay2_o(relay2_o),
      .analog_en_o(an_en), .analog_current_o(an_cur),
      .analog_value_o(an_val));

   paoa_field i_fld (
      .clk_i(clk_i), .relay1_i(relay1_o), .relay2_i(relay2_o), .raw_o(raw));

   ////////////////////////////////////////////////////////////////////////////
   // shared helpers
   task automatic end_of_test;
      if (n_fail == 0 && tests_run > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("FAIL %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // both channels offered together; each dropped once taken
   task automatic wr_x(input logic [7:0] a, input logic [31:0] d,
                       input logic [1:0] er);
      logic aw, w;
      int n;
      aw = 1'b1;
      w = 1'b1;
      n = 0;
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hF;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      while (n < 200) begin
         @(posedge clk_i);
         n++;
         if (bvalid === 1'b1) break;
         if (aw && awready === 1'b1) begin
            aw = 1'b0;
            awvalid <= 1'b0;
         end
         if (w && wready === 1'b1) begin
            w = 1'b0;
            wvalid <= 1'b0;
         end
      end
      check("bvalid", {31'h0, bvalid}, 32'h1);
      check("bresp", {30'h0, bresp}, {30'h0, er});
      bready <= 1'b0;
      @(posedge clk_i);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      wr_x(a, d, paoa_pkg::RESP_OKAY);
   endtask

   // data compared only on an accepted read
   task automatic rd(input logic [7:0] a, input logic [31:0] ed,
                     input logic [1:0] er);
      int n;
      n = 0;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      while (n < 200) begin
         @(posedge clk_i);
         n++;
         if (rvalid === 1'b1) break;
         if (arready === 1'b1) arvalid <= 1'b0;
      end
      check("rvalid", {31'h0, rvalid}, 32'h1);
      check("rresp", {30'h0, rresp}, {30'h0, er});
      if (er === paoa_pkg::RESP_OKAY) check("rdata", rdata, ed);
      rready <= 1'b0;
      @(posedge clk_i);
   endtask

   // sync, scaling and alarm stages all land well inside eight edges
   task automatic settle;
      repeat (8) @(posedge clk_i);
   endtask

   task automatic put_raw(input logic [15:0] v);
      i_fld.set_level(v);
      settle();
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // scenarios
   task automatic t_scale;
      logic [31:0] fac [4] = '{32'd100, 32'd10, 32'd1, 32'd500};
      put_raw(16'h0007);
      for (int r = 0; r < 4; r++) begin
         wr(paoa_pkg::OFF_CFG, 32'h10 | r);
         settle();
         rd(paoa_pkg::OFF_PV, 32'd7 * fac[r],
            paoa_pkg::RESP_OKAY);
      end
      wr(paoa_pkg::OFF_CFG, 32'h13);
   endtask

   // far-off first setpoint must not move absolute thresholds
   task automatic t_modes;
      logic e;
      int pv;
      wr(paoa_pkg::OFF_SP1, 32'h000186A0);
      wr(paoa_pkg::OFF_AL1_LO, 32'h3E8);
      wr(paoa_pkg::OFF_AL1_HI, 32'h7D0);
      for (int m = 0; m < 3; m++) begin
         wr(paoa_pkg::OFF_AL1_CFG, 32'h41 | (m << 4));
         for (int k = 0; k < 3; k++) begin
            put_raw(16'(1 + 2 * k));
            pv = 500 * (1 + 2 * k);
            e = (m != 1 && pv > 2000) || (m != 0 && pv < 1000);
            check("relay1_mode", relay1_o, e);
            check("relay1_abs", relay1_o, e);
         end
      end
   endtask

   task automatic t_nc;
      wr(paoa_pkg::OFF_AL1_CFG, 32'h49);
      put_raw(16'h0001);
      check("relay1_nc_idle", relay1_o, 1);
      put_raw(16'h0005);
      check("relay1_nc_alarm", relay1_o, 0);
   endtask

   task automatic t_latch;
      wr(paoa_pkg::OFF_AL1_CFG, 32'h45);
      put_raw(16'h0005);
      put_raw(16'h0001);
      check("relay1_held", relay1_o, 1);
      wr(paoa_pkg::OFF_AL1_CFG, 32'h41);
      wr(paoa_pkg::OFF_AL1_CFG, 32'h45);
      settle();
      check("relay1_relatch", relay1_o, 0);
      put_raw(16'h0005);
      put_raw(16'h0001);
      check("relay1_held2", relay1_o, 1);
      wr(paoa_pkg::OFF_CFG, 32'h03);
      wr(paoa_pkg::OFF_CFG, 32'h13);
      settle();
      check("relay1_standby", relay1_o, 0);
      wr(paoa_pkg::OFF_AL1_CFG, 32'h41);
      put_raw(16'h0005);
      put_raw(16'h0001);
      check("relay1_follow", relay1_o, 0);
   endtask

   // second alarm band of 600 either side of its own setpoint
   task automatic t_band;
      wr(paoa_pkg::OFF_SP1, 32'h0);
      wr(paoa_pkg::OFF_AL2_HI, 32'h258);
      wr(paoa_pkg::OFF_SP2, 32'h5DC);
      wr(paoa_pkg::OFF_AL2_CFG, 32'h73);
      put_raw(16'h0003);
      check("relay2_in_band", relay2_o, 0);
      put_raw(16'h0005);
      check("relay2_over", relay2_o, 1);
      put_raw(16'h0001);
      check("relay2_under", relay2_o, 1);
      wr(paoa_pkg::OFF_SP2, 32'h9C4);
      put_raw(16'h0005);
      check("relay2_moved", relay2_o, 0);
      wr(paoa_pkg::OFF_SP1, 32'h1F4);
      settle();
      check("relay2_sp1", relay2_o, 0);
      wr(paoa_pkg::OFF_AL2_CFG, 32'h71);
      put_raw(16'h0001);
      check("relay2_abs_band", relay2_o, 0);
   endtask

   task automatic t_analog;
      analog_opt_i <= 1'b1;
      ctl_out2_i <= 1'b1;
      wr(paoa_pkg::OFF_AL2_CFG, 32'h0);
      wr(paoa_pkg::OFF_CFG, 32'h1F);
      put_raw(16'h0005);
      check("analog_en", an_en, 1);
      check("relay1_analog", relay1_o, 0);
      check("analog_cur", an_cur, 1);
      check("analog_val", an_val, 16'h09C4);
      check("relay2_ctl", relay2_o, 1);
      wr(paoa_pkg::OFF_CFG, 32'h17);
      settle();
      check("analog_volt", an_cur, 0);
      analog_opt_i <= 1'b0;
      settle();
      check("analog_absent", an_en, 0);
      wr(paoa_pkg::OFF_CFG, 32'h13);
      wr(paoa_pkg::OFF_AL1_CFG, 32'h0);
      ctl_out1_i <= 1'b0;
      settle();
      check("relay1_ctl", relay1_o, 0);
   endtask

   // mid-run reset, then an alarm enabled inside its alarm region
   task automatic t_power;
      i_fld.set_level(16'h0005);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      wr(paoa_pkg::OFF_AL1_HI, 32'h7D0);
      wr(paoa_pkg::OFF_AL1_CFG, 32'h01);
      settle();
      check("relay1_wait", relay1_o, 0);
      put_raw(16'h0001);
      put_raw(16'h0005);
      check("relay1_armed", relay1_o, 1);
      wr(paoa_pkg::OFF_SP1, 32'h7D0);
      wr(paoa_pkg::OFF_AL1_CFG, 32'h53);
      settle();
      check("relay1_dev_ok", relay1_o, 0);
      put_raw(16'h0001);
      check("relay1_dev_low", relay1_o, 1);
   endtask

   task automatic t_bus;
      wr_x(8'h2C, 32'h0, paoa_pkg::RESP_SLVERR);
      rd(8'h2C, 32'h0, paoa_pkg::RESP_SLVERR);
      rd(paoa_pkg::OFF_AL2_LO, 32'h0, paoa_pkg::RESP_OKAY);
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // main sequence and hang guard
   initial begin
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      @(posedge clk_i);
      rd(paoa_pkg::OFF_CFG, 32'h13, paoa_pkg::RESP_OKAY);
      rd(paoa_pkg::OFF_AL1_CFG, 32'h0, paoa_pkg::RESP_OKAY);
      t_scale();
      t_modes();
      t_nc();
      t_latch();
      t_band();
      t_analog();
      t_power();
      t_bus();
      end_of_test();
   end

   // the sequence needs well under a thousand cycles; this allows thirty thousand
   initial begin
      repeat (30000) @(posedge clk_i);
      n_fail++;
      end_of_test();
   end
endmodule

// *** hw/paoa_top.sv ***
`timescale 1ns/1ps
// How it works
// - scale input by 100, 10, 1 or 500
// - only six legal pairings of two outputs
// - analog slot only with option fitted
// - first alarm enabled takes output one unless analog is on
// - analog enabled takes output one slot
// - absolute thresholds ignore the first setpoint
// - deviation thresholds are offsets from setpoint
// - latched alarm holds until reset, unlatch or standby
// - unlatch-relatch or standby-run clears latch
// - unlatched alarm follows condition only
// - normally open energizes only on alarm
// - normally closed de-energizes on alarm
// - above compares against high threshold only
// - below compares against low threshold only
// - hi/low alarms outside both thresholds
// - band alarms outside setpoint plus/minus high
// - band works only in deviation mode
// - each band centres on its own setpoint
// - band value is a relative width
// - power-on enabled alarm is live after reset
// - otherwise alarm waits for non-alarm region
// - analog output selectable current or voltage
module paoa_top (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // sensor, option strap and control outputs
   input wire logic [15:0] raw_i,
   input wire logic analog_opt_i,
   input wire logic ctl_out1_i,
   input wire logic ctl_out2_i,
   // axi4-lite write
   input wire logic [7:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // axi4-lite read
   input wire logic [7:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // physical outputs
   output logic relay1_o,
   output logic relay2_o,
   output logic analog_en_o,
   output logic analog_current_o,
   output logic [15:0] analog_value_o
);

   paoa_pkg::paoa_st_t s_r;
   paoa_pkg::paoa_st_t s_nxt;
   logic [1:0] cond_w;

   /////////////////////////////////////////////////////////////////////////////
   // scaled process value from raw reading
   function automatic paoa_pkg::paoa_val_t scale(input logic [15:0] raw,
                                                input logic [1:0] rng);
      logic [31:0] f;
      f = paoa_pkg::FAC_20MA;
      if (rng == paoa_pkg::RNG_100MV) begin
         f = paoa_pkg::FAC_100MV;
      end else if (rng == paoa_pkg::RNG_1V) begin
         f = paoa_pkg::FAC_1V;
      end else if (rng == paoa_pkg::RNG_10V) begin
         f = paoa_pkg::FAC_10V;
      end
      return paoa_pkg::paoa_val_t'({16'h0000, raw} * f);
   endfunction

   // raw alarm condition, shared by both alarms
   function automatic logic al_cond(input paoa_pkg::paoa_alcfg_t c,
                                    input paoa_pkg::paoa_val_t lo,
                                    input paoa_pkg::paoa_val_t hi,
                                    input paoa_pkg::paoa_val_t sp,
                                    input paoa_pkg::paoa_val_t pv);
      paoa_pkg::paoa_val_t elo;
      paoa_pkg::paoa_val_t ehi;
      paoa_pkg::paoa_val_t bhi;
      paoa_pkg::paoa_val_t blo;
      logic r;
      // deviation moves thresholds with setpoint
      elo = c.dev ? paoa_pkg::paoa_val_t'(sp + lo) : lo;
      ehi = c.dev ? paoa_pkg::paoa_val_t'(sp + hi) : hi;
      // band is a width around setpoint
      bhi = paoa_pkg::paoa_val_t'(sp + hi);
      blo = paoa_pkg::paoa_val_t'(sp - hi);
      case (c.mode)
         paoa_pkg::MODE_ABOVE: r = pv > ehi;
         paoa_pkg::MODE_BELOW: r = pv < elo;
         paoa_pkg::MODE_HILO: r = (pv < elo) || (pv > ehi);
         // absolute band is not offered, so it never alarms
         default: r = c.dev && ((pv > bhi) || (pv < blo));
      endcase
      return r;
   endfunction

   // byte-lane merge of a write into a word
   function automatic logic [31:0] merge(input logic [31:0] old,
                                         input logic [31:0] d,
                                         input logic [3:0] strb);
      logic [31:0] m;
      m = old;
      for (int b = 0; b < 4; b++) begin
         if (strb[b]) begin
            m[b*8 +: 8] = d[b*8 +: 8];
         end
      end
      return m;
   endfunction

   /////////////////////////////////////////////////////////////////////////////
   // next state: sync, alarms, output steering, bus slave
   always_comb begin
      logic [31:0] m;
      logic [31:0] rd;
      logic [1:0] rly;
      logic ca;
      logic an_on;
      m = '0;
      rd = '0;
      rly = '0;
      ca = 1'b0;
      an_on = 1'b0;
      s_nxt = s_r;
      // two-flop sync; raw bits may tear between samples
      s_nxt.raw_m = raw_i;
      s_nxt.raw_s = s_r.raw_m;
      s_nxt.opt_m = analog_opt_i;
      s_nxt.opt_s = s_r.opt_m;
      s_nxt.pv = scale(s_r.raw_s, s_r.cfg.rng);
      // each alarm uses its own setpoint
      for (int i = 0; i < 2; i++) begin
         cond_w[i] = al_cond(s_r.al[i], s_r.lo[i], s_r.hi[i], s_r.sp[i],
                             s_r.pv);
         // armed at once, or on first non-alarm sample
         ca = cond_w[i] & (s_r.armed[i] | s_r.al[i].pwr_on);
         // only an enabled alarm arms on a quiet sample, so the empty reading after reset
         // cannot pass for a first non-alarm sample
         s_nxt.armed[i] = s_r.armed[i] | s_r.al[i].pwr_on |
                          (s_r.al[i].en & ~cond_w[i]);
         // new condition wins over any clear
         s_nxt.act[i] = ca | (s_r.al[i].latch & s_r.act[i] & s_r.cfg.run);
         rly[i] = s_nxt.act[i] ^ s_r.al[i].nc;
      end
      // output steering keeps only legal pairings
      an_on = s_r.cfg.an_en & s_r.opt_s;
      s_nxt.analog_en = an_on;
      if (an_on) begin
         s_nxt.relay1 = 1'b0;
      end else if (s_r.al[0].en) begin
         s_nxt.relay1 = rly[0];
      end else begin
         s_nxt.relay1 = ctl_out1_i;
      end
      s_nxt.relay2 = s_r.al[1].en ? rly[1] : ctl_out2_i;

      // write address and data taken independently, in either order
      if (s_axi_awvalid_i && s_r.awready) begin
         s_nxt.aw_ok = 1'b1;
         s_nxt.awaddr = s_axi_awaddr_i;
      end
      if (s_axi_wvalid_i && s_r.wready) begin
         s_nxt.w_ok = 1'b1;
         s_nxt.wdata = s_axi_wdata_i;
         s_nxt.wstrb = s_axi_wstrb_i;
      end
      if (s_r.bvalid && s_axi_bready_i) begin
         s_nxt.bvalid = 1'b0;
      end
      if (s_r.aw_ok && s_r.w_ok) begin
         s_nxt.aw_ok = 1'b0;
         s_nxt.w_ok = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = paoa_pkg::RESP_OKAY;
         if (s_r.awaddr == paoa_pkg::OFF_CFG) begin
            m = merge({27'h0, s_r.cfg}, s_r.wdata, s_r.wstrb);
            s_nxt.cfg = paoa_pkg::paoa_cfg_t'(m[4:0]);
         end else if (s_r.awaddr == paoa_pkg::OFF_AL1_CFG) begin
            m = merge({25'h0, s_r.al[0]}, s_r.wdata, s_r.wstrb);
            s_nxt.al[0] = paoa_pkg::paoa_alcfg_t'(m[6:0]);
         end else if (s_r.awaddr == paoa_pkg::OFF_AL2_CFG) begin
            m = merge({25'h0, s_r.al[1]}, s_r.wdata, s_r.wstrb);
            s_nxt.al[1] = paoa_pkg::paoa_alcfg_t'(m[6:0]);
         end else if (s_r.awaddr == paoa_pkg::OFF_AL1_LO) begin
            s_nxt.lo[0] = merge(s_r.lo[0], s_r.wdata, s_r.wstrb);
         end else if (s_r.awaddr == paoa_pkg::OFF_AL1_HI) begin
            s_nxt.hi[0] = merge(s_r.hi[0], s_r.wdata, s_r.wstrb);
         end else if (s_r.awaddr == paoa_pkg::OFF_AL2_LO) begin
            s_nxt.lo[1] = merge(s_r.lo[1], s_r.wdata, s_r.wstrb);
         end else if (s_r.awaddr == paoa_pkg::OFF_AL2_HI) begin
            s_nxt.hi[1] = merge(s_r.hi[1], s_r.wdata, s_r.wstrb);
         end else if (s_r.awaddr == paoa_pkg::OFF_SP1) begin
            s_nxt.sp[0] = merge(s_r.sp[0], s_r.wdata, s_r.wstrb);
         end else if (s_r.awaddr == paoa_pkg::OFF_SP2) begin
            s_nxt.sp[1] = merge(s_r.sp[1], s_r.wdata, s_r.wstrb);
         end else if (s_r.awaddr == paoa_pkg::OFF_STAT ||
                      s_r.awaddr == paoa_pkg::OFF_PV) begin
            s_nxt.bresp = paoa_pkg::RESP_OKAY; // read-only, write dropped
         end else begin
            s_nxt.bresp = paoa_pkg::RESP_SLVERR;
         end
      end
      // one write in flight: stall both channels until answered
      s_nxt.awready = ~s_nxt.aw_ok & ~s_nxt.bvalid;
      s_nxt.wready = ~s_nxt.w_ok & ~s_nxt.bvalid;

      // read answer one cycle after the address is taken
      if (s_r.rvalid && s_axi_rready_i) begin
         s_nxt.rvalid = 1'b0;
      end
      if (s_axi_arvalid_i && s_r.arready) begin
         s_nxt.rvalid = 1'b1;
         s_nxt.rresp = paoa_pkg::RESP_OKAY;
         if (s_axi_araddr_i == paoa_pkg::OFF_CFG) begin
            rd = {27'h0, s_r.cfg};
         end else if (s_axi_araddr_i == paoa_pkg::OFF_AL1_CFG) begin
            rd = {25'h0, s_r.al[0]};
         end else if (s_axi_araddr_i == paoa_pkg::OFF_AL2_CFG) begin
            rd = {25'h0, s_r.al[1]};
         end else if (s_axi_araddr_i == paoa_pkg::OFF_AL1_LO) begin
            rd = s_r.lo[0];
         end else if (s_axi_araddr_i == paoa_pkg::OFF_AL1_HI) begin
            rd = s_r.hi[0];
         end else if (s_axi_araddr_i == paoa_pkg::OFF_AL2_LO) begin
            rd = s_r.lo[1];
         end else if (s_axi_araddr_i == paoa_pkg::OFF_AL2_HI) begin
            rd = s_r.hi[1];
         end else if (s_axi_araddr_i == paoa_pkg::OFF_SP1) begin
            rd = s_r.sp[0];
         end else if (s_axi_araddr_i == paoa_pkg::OFF_SP2) begin
            rd = s_r.sp[1];
         end else if (s_axi_araddr_i == paoa_pkg::OFF_STAT) begin
            rd = {23'h0, s_r.opt_s, s_r.relay2, s_r.relay1,
                  s_r.armed, s_r.act, cond_w};
         end else if (s_axi_araddr_i == paoa_pkg::OFF_PV) begin
            rd = s_r.pv;
         end else begin
            s_nxt.rresp = paoa_pkg::RESP_SLVERR;
         end
         s_nxt.rdata = rd;
      end
      s_nxt.arready = ~s_nxt.rvalid;
   end

   /////////////////////////////////////////////////////////////////////////////
   // the only register stage
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         s_r <= paoa_pkg::ST_RST;
      end else begin
         s_r <= s_nxt;
      end
   end

   // every output is a state bit
   assign s_axi_awready_o = s_r.awready;
   assign s_axi_wready_o = s_r.wready;
   assign s_axi_bvalid_o = s_r.bvalid;
   assign s_axi_bresp_o = s_r.bresp;
   assign s_axi_arready_o = s_r.arready;
   assign s_axi_rvalid_o = s_r.rvalid;
   assign s_axi_rdata_o = s_r.rdata;
   assign s_axi_rresp_o = s_r.rresp;
   assign relay1_o = s_r.relay1;
   assign relay2_o = s_r.relay2;
   assign analog_en_o = s_r.analog_en;
   assign analog_current_o = s_r.cfg.an_cur;
   assign analog_value_o = s_r.pv[15:0];

   /////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   sequence seq_range_held;
      s_r.cfg.rng == paoa_pkg::RNG_20MA ##1 s_r.cfg.rng == paoa_pkg::RNG_20MA;
   endsequence
   sequence seq_latched_run;
      s_r.act[0] && s_r.al[0].latch && s_r.cfg.run;
   endsequence
   sequence seq_idle_standby;
      !s_r.cfg.run && !cond_w[0];
   endsequence

   chk_scale_pv: assert property (seq_range_held |->
      s_r.pv == paoa_pkg::paoa_val_t'({16'h0000, $past(s_r.raw_s)} *
                                      paoa_pkg::FAC_20MA))
      else $error("process value not scaled by range factor");
   chk_out_pairing: assert property (analog_en_o |-> !relay1_o)
      else $error("analog slot and relay one both active");
   chk_analog_opt: assert property (!s_r.opt_s |=> !analog_en_o)
      else $error("analog enabled without option");
   chk_out1_alarm: assert property (
      s_r.al[0].en && !(s_r.cfg.an_en && s_r.opt_s) |=>
      relay1_o == (s_r.act[0] ^ $past(s_r.al[0].nc)))
      else $error("relay one not driven by first alarm");
   chk_out1_analog: assert property (
      s_r.cfg.an_en && s_r.opt_s |=> analog_en_o && !relay1_o)
      else $error("analog did not take output one");
   chk_latch_hold: assert property (seq_latched_run |=> s_r.act[0])
      else $error("latched alarm dropped");
   chk_standby_clear: assert property (
      seq_idle_standby |=> !s_r.act[0])
      else $error("standby did not clear latch");
   chk_unlatch_follow: assert property (
      !s_r.al[1].latch && !cond_w[1] |=> !s_r.act[1])
      else $error("unlatched alarm outlived condition");
   chk_relay_pol: assert property (s_r.al[1].en |=>
      relay2_o == (s_r.act[1] ^ $past(s_r.al[1].nc)))
      else $error("relay two polarity wrong");
   chk_above_abs: assert property (
      s_r.al[0].mode == paoa_pkg::MODE_ABOVE && !s_r.al[0].dev &&
      s_r.pv > s_r.hi[0] |-> cond_w[0])
      else $error("above mode missed alarm");
   chk_below_dev: assert property (
      s_r.al[0].mode == paoa_pkg::MODE_BELOW && s_r.al[0].dev &&
      s_r.pv >= paoa_pkg::paoa_val_t'(s_r.sp[0] + s_r.lo[0]) |-> !cond_w[0])
      else $error("deviation below alarm too early");
   chk_band_abs: assert property (
      s_r.al[1].mode == paoa_pkg::MODE_BAND && !s_r.al[1].dev |-> !cond_w[1])
      else $error("band alarm in absolute mode");
   chk_power_wait: assert property (
      !s_r.armed[0] && !s_r.al[0].pwr_on && !s_r.act[0] |=> !s_r.act[0])
      else $error("alarm live before non-alarm region");

   // output steering when no alarm or analog claims a slot
   chk_out1_ctl: assert property (
      !s_r.al[0].en && !(s_r.cfg.an_en && s_r.opt_s) |=>
      relay1_o == $past(ctl_out1_i))
      else $error("relay one not following control output");
   chk_out2_ctl: assert property (
      !s_r.al[1].en |=> relay2_o == $past(ctl_out2_i))
      else $error("relay two not following control output");

   // clearing the latch bit drops a quiet alarm at once
   chk_unlatch_clear: assert property (
      s_r.act[0] && !s_r.al[0].latch && !cond_w[0] |=> !s_r.act[0])
      else $error("unlatching did not clear alarm");

   // absolute modes compare against the plain thresholds; band against setpoint plus high
   chk_below_abs: assert property (
      s_r.al[0].mode == paoa_pkg::MODE_BELOW && !s_r.al[0].dev &&
      s_r.pv < s_r.lo[0] |-> cond_w[0])
      else $error("below mode missed alarm");
   chk_hilo_low: assert property (
      s_r.al[0].mode == paoa_pkg::MODE_HILO && !s_r.al[0].dev &&
      s_r.pv < s_r.lo[0] |-> cond_w[0])
      else $error("hi/low mode missed low alarm");
   chk_band_over: assert property (
      s_r.al[1].mode == paoa_pkg::MODE_BAND && s_r.al[1].dev &&
      s_r.pv > paoa_pkg::paoa_val_t'(s_r.sp[1] + s_r.hi[1]) |-> cond_w[1])
      else $error("band mode missed alarm above band");

   // arming: at once with power-on set, else only while enabled
   chk_power_live: assert property (
      s_r.al[0].pwr_on && cond_w[0] |=> s_r.act[0])
      else $error("power-on alarm not live");
   chk_arm_enabled: assert property (
      !s_r.armed[0] && !s_r.al[0].en && !s_r.al[0].pwr_on |=> !s_r.armed[0])
      else $error("disabled alarm armed itself");

endmodule
